// ==== rtl/dbg_err_pkg.sv ====
package dbg_err_pkg;
	localparam int CLK_FREQ_HZ = 40000000;
	localparam int BREAK_BITS = 9;
	localparam int RETURN_BREAK_CHARS = 4;
	localparam int BITS_PER_CHAR = 10;
	localparam int CAL_LOW_BITS = 8;
	localparam int MIN_BAUD_DIV = 512;
	localparam int CNT_W = 16;
	localparam int BIT_W = 12;
	localparam logic [BIT_W-1:0] BIT_PERIOD_RESET = 12'h000;
	localparam int STOP_BIT_INDEX = 9;
endpackage

// ==== rtl/dbg_line_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dbg_line_if;
	logic line_in;
	logic line_sync;
	modport sync_side(input line_in, output line_sync);
	modport user_side(output line_in, input line_sync);
endinterface
`default_nettype wire

// ==== rtl/dbg_line_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbg_line_sync (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	dbg_line_if.sync_side line
);
	logic meta_reg;
	logic sync_reg;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= line.line_in;
			sync_reg <= meta_reg;
		end
	end
	assign line.line_sync = sync_reg;
endmodule
`default_nettype wire

// ==== rtl/debug_serial_error_handler.sv ====
// Functional notes
// R1 - Flag a serial break when the line stays low for nine or more bit periods.
// R2 - Flag a framing error when the stop bit of a received character is low.
// R3 - Flag a transmit collision when the host drives the line while we send.
// R4 - On any error, abort the debug command in progress without completing it.
// R5 - After an error, drive the line low for four character times as a break.
// R6 - After an error, reset the auto-baud logic and discard the measured rate.
// R7 - Errors caused by an incoming host break get the same full response.
// R8 - Both parties only pull the line low, so the returned break merges with the host's.
// R9 - The host sends a break on attach and when recovering from an error.
// R10 - A host break resets only auto-baud; the control register keeps its contents.
// R11 - After reset, time the eight low bits of an 80H character to set the bit period.
// R12 - After a break the host sends 80H so the bit rate can be relearned.
// R13 - Auto-baud runs on the system clock and supports rates down to clock/512.
// R14 - The incoming line passes a two-stage synchroniser before any detection.
// R15 - While sending, a low seen during a released bit declares a collision.
`timescale 1ns/1ps
`default_nettype none
module debug_serial_error_handler
	import dbg_err_pkg::*;
#(
	parameter int CNT_WIDTH = CNT_W
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_line_in,
	input wire logic i_tx_active,
	input wire logic i_tx_drive_low,
	input wire logic i_rx_stop_sample,
	input wire logic i_ctrl_wr,
	input wire logic [7:0] i_ctrl_wdata,
	output logic o_line_out,
	output logic o_line_oe,
	output logic o_line_level,
	output logic o_abort,
	output logic o_break_err,
	output logic o_frame_err,
	output logic o_collision_err,
	output logic o_baud_valid,
	output logic [BIT_W-1:0] o_bit_period,
	output logic o_break_active,
	output logic [7:0] o_ctrl
);
	typedef enum {ST_CAL_IDLE, ST_CAL_LOW, ST_RUN, ST_RET_BREAK} state_t;

	localparam logic [CNT_WIDTH-1:0] MAX_PERIOD = CNT_WIDTH'(MIN_BAUD_DIV);
	localparam logic [CNT_WIDTH-1:0] CAL_MAX = CNT_WIDTH'(MIN_BAUD_DIV * CAL_LOW_BITS);

	dbg_line_if line_bus();
	assign line_bus.line_in = i_line_in;
	dbg_line_sync u_sync (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.line(line_bus.sync_side)
	);
	wire logic line_s = line_bus.line_sync; // [R14]

	state_t state_reg;
	state_t state_next;
	logic [CNT_WIDTH-1:0] low_cnt_reg;
	logic [CNT_WIDTH-1:0] cal_cnt_reg;
	logic [CNT_WIDTH-1:0] brk_cnt_reg;
	logic [BIT_W-1:0] bit_period_reg;
	logic baud_valid_reg;
	logic [7:0] ctrl_reg;
	logic [CNT_WIDTH-1:0] ret_len_reg;
	// Own drive level as the synchroniser will show it
	logic oe_d1_reg;
	logic oe_d2_reg;

	// Break threshold scaled from learned bit period
	wire logic [CNT_WIDTH-1:0] break_len = CNT_WIDTH'(bit_period_reg * BREAK_BITS);
	wire logic [CNT_WIDTH-1:0] ret_len =
		CNT_WIDTH'(bit_period_reg * (RETURN_BREAK_CHARS * BITS_PER_CHAR));
	wire logic break_det = baud_valid_reg && !line_s && (low_cnt_reg + 1'b1 >= break_len); // [R1]
	wire logic frame_det = (state_reg == ST_RUN) && i_rx_stop_sample && !line_s; // [R2] [R7]
	// Released bit yet line low means the host is driving
	wire logic coll_det = (state_reg == ST_RUN) && i_tx_active && !oe_d2_reg && !line_s; // [R3] [R15] [R7]
	wire logic any_err = (state_reg == ST_RUN) && (break_det || frame_det || coll_det);
	wire logic cal_done = (state_reg == ST_CAL_LOW) && line_s;
	wire logic [CNT_WIDTH-1:0] cal_period = cal_cnt_reg / CNT_WIDTH'(CAL_LOW_BITS);
	wire logic cal_ok = cal_done && (cal_period != '0) && (cal_period <= MAX_PERIOD); // [R13]
	// Length latched at the error, before the rate is cleared
	wire logic brk_done = (state_reg == ST_RET_BREAK) && (brk_cnt_reg + 1'b1 >= ret_len_reg);
	wire logic drive_low = (state_reg == ST_RET_BREAK && !brk_done) ||
		(state_next == ST_RET_BREAK) || (state_reg == ST_RUN && i_tx_active && i_tx_drive_low && !any_err);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_CAL_IDLE: begin
				if (!line_s) begin
					state_next = ST_CAL_LOW; // [R11]
				end
			end
			ST_CAL_LOW: begin
				if (cal_done) begin
					state_next = cal_ok ? ST_RUN : ST_CAL_IDLE;
				end else if (cal_cnt_reg >= CAL_MAX) begin
					state_next = ST_CAL_IDLE;
				end
			end
			ST_RUN: begin
				if (any_err) begin
					state_next = ST_RET_BREAK; // [R4] [R5]
				end
			end
			ST_RET_BREAK: begin
				if (brk_done) begin
					state_next = ST_CAL_IDLE; // [R6]
				end
			end
			default: begin
				state_next = ST_CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= ST_CAL_IDLE;
			low_cnt_reg <= '0;
			cal_cnt_reg <= '0;
			brk_cnt_reg <= '0;
			oe_d1_reg <= 1'b0;
			oe_d2_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			oe_d1_reg <= o_line_oe; // [R15]
			oe_d2_reg <= oe_d1_reg;
			low_cnt_reg <= (line_s || &low_cnt_reg) ? (line_s ? '0 : low_cnt_reg) : low_cnt_reg + 1'b1;
			// Counts the first low cycle as well
			cal_cnt_reg <= (state_next == ST_CAL_LOW) ? cal_cnt_reg + 1'b1 : '0; // [R11]
			brk_cnt_reg <= (state_reg == ST_RET_BREAK) ? brk_cnt_reg + 1'b1 : '0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bit_period_reg <= BIT_PERIOD_RESET;
			baud_valid_reg <= 1'b0;
			ret_len_reg <= '0;
		end else if (any_err) begin
			ret_len_reg <= ret_len; // [R5]
			bit_period_reg <= BIT_PERIOD_RESET; // [R6] [R10]
			baud_valid_reg <= 1'b0;
		end else if (cal_ok) begin
			bit_period_reg <= BIT_W'(cal_period); // [R11]
			baud_valid_reg <= 1'b1;
		end
	end

	// Control register untouched by errors and breaks
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_reg <= 8'h00;
		end else if (i_ctrl_wr) begin
			ctrl_reg <= i_ctrl_wdata; // [R10]
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_line_out <= 1'b0;
			o_line_oe <= 1'b0;
			o_line_level <= 1'b1;
			o_abort <= 1'b0;
			o_break_err <= 1'b0;
			o_frame_err <= 1'b0;
			o_collision_err <= 1'b0;
			o_baud_valid <= 1'b0;
			o_bit_period <= BIT_PERIOD_RESET;
			o_break_active <= 1'b0;
			o_ctrl <= 8'h00;
		end else begin
			o_line_out <= 1'b0; // [R8]
			o_line_oe <= drive_low; // [R8] [R5]
			o_line_level <= line_s;
			o_abort <= any_err; // [R4]
			o_break_err <= any_err && break_det;
			o_frame_err <= any_err && frame_det;
			o_collision_err <= any_err && coll_det;
			o_baud_valid <= baud_valid_reg;
			o_bit_period <= bit_period_reg;
			o_break_active <= (state_next == ST_RET_BREAK);
			o_ctrl <= ctrl_reg;
		end
	end

	sequence error_answered;
		o_abort && o_line_oe;
	endsequence
	sequence break_reported;
		o_break_err ##1 o_break_active;
	endsequence

	chk_abort_on_error: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R4]
		any_err |=> error_answered) else $error("error not aborted");
	chk_baud_cleared: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R6]
		any_err |=> !baud_valid_reg) else $error("baud not reset");
	chk_ctrl_kept: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R10]
		!i_ctrl_wr |=> ctrl_reg == $past(ctrl_reg)) else $error("ctrl changed");
	chk_never_drive_high: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R8]
		o_line_out == 1'b0) else $error("line driven high");
	chk_break_held: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R5]
		(state_reg == ST_RET_BREAK && !brk_done) |=> o_line_oe) else $error("break released");
	chk_frame_flag: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R2]
		frame_det |=> o_frame_err) else $error("framing missed");
	chk_coll_flag: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R3]
		coll_det |=> o_collision_err && o_abort) else $error("collision missed");
	chk_break_flag: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R1]
		(state_reg == ST_RUN && break_det) |=> break_reported) else $error("break missed");
	chk_period_limit: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R13]
		baud_valid_reg |-> (bit_period_reg != 0 && bit_period_reg <= MIN_BAUD_DIV)) else $error("bad period");
	chk_line_sync: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R14]
		o_line_level == $past(i_line_in, 3)) else $error("line level not synchronised");
	chk_break_release: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R5]
		brk_done |=> !o_line_oe) else $error("break not released");
	chk_cal_restart: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R6]
		brk_done |=> state_reg == ST_CAL_IDLE && !baud_valid_reg) else $error("auto-baud not restarted");
	chk_abort_cause: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [R4]
		o_abort |-> o_break_err || o_frame_err || o_collision_err) else $error("abort without error");
endmodule
`default_nettype wire

// ==== sim/dbg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbg_host_model (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_go,
	input wire logic [15:0] i_len,
	output logic o_pull_low
);
	logic [15:0] cnt_reg;
	// Host only ever pulls the line low, for a break, the 80H low run, a low stop bit or a collision
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) cnt_reg <= 16'h0000;
		else if (i_go) cnt_reg <= i_len;
		else if (cnt_reg != 16'h0000) cnt_reg <= cnt_reg - 16'h0001;
	end
	assign o_pull_low = (cnt_reg != 16'h0000);
endmodule
`default_nettype wire

// ==== sim/debug_serial_error_handler_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module debug_serial_error_handler_tb;
	import dbg_err_pkg::*;
	localparam int P = 8;
	logic i_ref_clk = 0, i_resetn = 0, tx_active = 0, tx_low = 0, stop_smp = 0, ctrl_wr = 0, go = 0;
	logic [7:0] ctrl_wdata = 8'h00;
	logic [15:0] len = 16'h0000;
	logic line_out, line_oe, line_level, abort, brk, frm, col, baud_ok, brk_act, host_low;
	logic [BIT_W-1:0] period;
	logic [7:0] ctrl;
	int fails = 0, n_compared = 0, cyc = 0, n;
	wire logic line = !(host_low || (line_oe && !line_out));
	debug_serial_error_handler i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_line_in(line),
		.i_tx_active(tx_active), .i_tx_drive_low(tx_low), .i_rx_stop_sample(stop_smp), .i_ctrl_wr(ctrl_wr),
		.i_ctrl_wdata(ctrl_wdata), .o_line_out(line_out), .o_line_oe(line_oe), .o_line_level(line_level),
		.o_abort(abort), .o_break_err(brk), .o_frame_err(frm), .o_collision_err(col), .o_baud_valid(baud_ok),
		.o_bit_period(period), .o_break_active(brk_act), .o_ctrl(ctrl));
	dbg_host_model i_host (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_go(go), .i_len(len),
		.o_pull_low(host_low));
	initial forever #12.5 i_ref_clk = ~i_ref_clk;
	task automatic test_done();
		if (fails == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			test_done();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic host_go(input int k);
		go = 1;
		len = 16'(k);
		tick(1);
		go = 0;
	endtask
	task automatic wait_abort(input int lim);
		n = 0;
		while (abort !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		check(abort, 1'b1);
	endtask
	task automatic calibrate();
		host_go(8 * P);
		tick(8 * P + 20);
		check(baud_ok, 1'b1);
		check(period, 12'(P));
	endtask
	task automatic recover();
		tick(1);
		check(line_oe, 1'b1);
		check(brk_act, 1'b1);
		n = 0;
		while (line_oe === 1'b1 && n < 500) begin
			if (n == 2 * P * BITS_PER_CHAR) check(line, 1'b0);
			tick(1);
			n++;
		end
		check(n >= RETURN_BREAK_CHARS * BITS_PER_CHAR * P - 1, 1'b1);
		check(n <= RETURN_BREAK_CHARS * BITS_PER_CHAR * P + 1, 1'b1);
		check(brk_act, 1'b0);
		check(baud_ok, 1'b0);
		tick(4);
		calibrate();
	endtask
	task automatic tx_case();
		tx_active = 1;
		tx_low = 1;
		tick(2);
		check(line_oe, 1'b1);
		tx_low = 0;
		n = 0;
		repeat (2 * P) begin
			tick(1);
			if (abort !== 1'b0) n++;
		end
		tx_active = 0;
		check(n, 0);
		check(line_oe, 1'b0);
	endtask
	task automatic break_case();
		ctrl_wr = 1;
		ctrl_wdata = 8'h5a;
		tick(1);
		ctrl_wr = 0;
		host_go(BREAK_BITS * P + 4);
		wait_abort(BREAK_BITS * P + 20);
		check({brk, frm, col}, 3'b100);
		recover();
		check(ctrl, 8'h5a);
	endtask
	task automatic frame_case();
		host_go(2 * P);
		tick(6);
		check(line_level, 1'b0);
		stop_smp = 1;
		tick(1);
		stop_smp = 0;
		wait_abort(10);
		check({brk, frm, col}, 3'b010);
		recover();
	endtask
	task automatic collision_case();
		tx_active = 1;
		host_go(P);
		wait_abort(20);
		check({brk, frm, col}, 3'b001);
		tx_active = 0;
		recover();
	endtask
	initial begin
		tick(5);
		i_resetn = 1;
		check({line_oe, line_level, abort, baud_ok, ctrl}, {4'b0100, 8'h00});
		tick(4);
		calibrate();
		tx_case();
		break_case();
		frame_case();
		collision_case();
		test_done();
	end
endmodule
`default_nettype wire
